// File: inc/dbu_regs.svh
`ifndef DBU_REGS_SVH
`define DBU_REGS_SVH
// register indices; byte address on the bus is four times the index
`define DBU_IDX_ADDR_HI 28'h5ffff90
`define DBU_IDX_ADDR_LO 28'h5ffff92
`define DBU_IDX_MASK_HI 28'h5ffff94
`define DBU_IDX_MASK_LO 28'h5ffff96
`define DBU_IDX_CYC_SEL 28'h5ffff98
`define DBU_IDX_STATUS 28'h5ffff9a
`define DBU_IDX_IRQ_MASK 28'h5ffff9c
`define DBU_CFG_RESET 16'h0000
// cycle select fields
`define DBU_SRC_POS 6
`define DBU_TYPE_POS 4
`define DBU_DIR_POS 2
`define DBU_SIZE_POS 0
`define DBU_CYC_SEL_USED 16'h00ff
// size encodings, shared by the field and the bus size input
`define DBU_SIZE_ANY 2'h0
// status and interrupt mask bits
`define DBU_ST_BREAK 0
`define DBU_ST_FETCH 1
`define DBU_ST_USED 16'h0003
`endif

// File: inc/dbu_pkg.sv
package dbu_pkg;
  typedef enum logic [2:0] {
    DBU_SLOT_ADDR_HI,
    DBU_SLOT_ADDR_LO,
    DBU_SLOT_MASK_HI,
    DBU_SLOT_MASK_LO,
    DBU_SLOT_CYC_SEL,
    DBU_SLOT_STATUS,
    DBU_SLOT_IRQ_MASK,
    DBU_SLOT_NONE
  } dbu_slot_t;
endpackage : dbu_pkg

// File: hdl/dbu_top.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "dbu_regs.svh"

module dbu_top #(
  parameter int CNT_W = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic bus_is_dma,
  input wire logic bus_is_fetch,
  input wire logic bus_is_write,
  input wire logic [1:0] bus_size,
  output logic break_req,
  output logic break_on_fetch,
  input wire logic break_ack,
  output logic irq
);

  logic [15:0] cfg_q [5];
  logic [15:0] cfg_d [5];
  logic [15:0] status_q, status_d;
  logic [15:0] imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  logic [CNT_W-1:0] pend_q, pend_d;
  logic fetch_q, fetch_d;
  logic break_req_q, break_req_d;
  logic match_hit;
  logic [31:0] cmp_addr, cmp_mask;
  dbu_pkg::dbu_slot_t slot;
  logic commit;
  logic [15:0] wmask;

  function automatic logic idx_hit(input logic [27:0] idx, input logic [27:0] ref_idx);
    idx_hit = (idx[27:24] == ref_idx[27:24]) && (idx[8:0] == ref_idx[8:0]);
  endfunction : idx_hit

  function automatic logic sel_ok(input logic [1:0] sel, input logic first, input logic second);
    sel_ok = (sel[0] & first) | (sel[1] & second);
  endfunction : sel_ok

  // register slot decode
  always_comb begin
    logic [27:0] idx;
    idx = paddr[29:2];
    slot = dbu_pkg::DBU_SLOT_NONE;
    if (paddr[31:30] == 2'h0) begin
      if (idx_hit(idx, `DBU_IDX_ADDR_HI)) slot = dbu_pkg::DBU_SLOT_ADDR_HI;
      else if (idx_hit(idx, `DBU_IDX_ADDR_LO)) slot = dbu_pkg::DBU_SLOT_ADDR_LO;
      else if (idx_hit(idx, `DBU_IDX_MASK_HI)) slot = dbu_pkg::DBU_SLOT_MASK_HI;
      else if (idx_hit(idx, `DBU_IDX_MASK_LO)) slot = dbu_pkg::DBU_SLOT_MASK_LO;
      else if (idx_hit(idx, `DBU_IDX_CYC_SEL)) slot = dbu_pkg::DBU_SLOT_CYC_SEL;
      else if (idx_hit(idx, `DBU_IDX_STATUS)) slot = dbu_pkg::DBU_SLOT_STATUS;
      else if (idx_hit(idx, `DBU_IDX_IRQ_MASK)) slot = dbu_pkg::DBU_SLOT_IRQ_MASK;
    end
  end

  assign commit = psel && penable && pready_q;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // break condition compare
  assign cmp_addr = {cfg_q[0], cfg_q[1]};
  assign cmp_mask = {cfg_q[2], cfg_q[3]};
  always_comb begin
    logic [15:0] cs;
    logic addr_ok;
    logic size_ok;
    cs = cfg_q[4];
    addr_ok = ((bus_addr ^ cmp_addr) & ~cmp_mask) == 32'h0000_0000;
    size_ok = (cs[`DBU_SIZE_POS +: 2] == `DBU_SIZE_ANY)
      || (cs[`DBU_SIZE_POS +: 2] == bus_size);
    match_hit = bus_valid && addr_ok && size_ok
      && sel_ok(cs[`DBU_SRC_POS +: 2], !bus_is_dma, bus_is_dma)
      && sel_ok(cs[`DBU_TYPE_POS +: 2], bus_is_fetch, !bus_is_fetch)
      && sel_ok(cs[`DBU_DIR_POS +: 2], !bus_is_write, bus_is_write);
  end

  // apb slave: one wait state, answer registered
  always_comb begin
    logic [15:0] rd;
    rd = 16'h0000;
    unique case (slot)
      dbu_pkg::DBU_SLOT_ADDR_HI: rd = cfg_q[0];
      dbu_pkg::DBU_SLOT_ADDR_LO: rd = cfg_q[1];
      dbu_pkg::DBU_SLOT_MASK_HI: rd = cfg_q[2];
      dbu_pkg::DBU_SLOT_MASK_LO: rd = cfg_q[3];
      dbu_pkg::DBU_SLOT_CYC_SEL: rd = cfg_q[4];
      dbu_pkg::DBU_SLOT_STATUS: rd = status_q;
      dbu_pkg::DBU_SLOT_IRQ_MASK: rd = imask_q;
      dbu_pkg::DBU_SLOT_NONE: rd = 16'h0000;
    endcase
    pready_d = psel && penable && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && penable && !pready_q) begin
      prdata_d = pwrite ? 32'h0000_0000 : {16'h0000, rd};
      pslverr_d = (slot == dbu_pkg::DBU_SLOT_NONE);
    end else if (!psel) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
    end
  end

  // setting registers
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      cfg_d[i] = cfg_q[i];
      if (commit && pwrite && (int'(slot) == i)) begin
        cfg_d[i] = (cfg_q[i] & ~wmask) | (pwdata[15:0] & wmask);
      end
    end
    cfg_d[4] = cfg_d[4] & `DBU_CYC_SEL_USED;
    imask_d = imask_q;
    if (commit && pwrite && slot == dbu_pkg::DBU_SLOT_IRQ_MASK) begin
      imask_d = ((imask_q & ~wmask) | (pwdata[15:0] & wmask)) & `DBU_ST_USED;
    end
  end

  // break request, status and interrupt
  always_comb begin
    logic inc;
    logic dec;
    inc = match_hit && (pend_q != {CNT_W{1'b1}});
    dec = break_ack && (pend_q != '0);
    pend_d = pend_q;
    if (inc && !dec) pend_d = pend_q + CNT_W'(1);
    else if (dec && !inc) pend_d = pend_q - CNT_W'(1);
    fetch_d = fetch_q;
    if (match_hit) fetch_d = bus_is_fetch;
    else if (pend_d == '0) fetch_d = 1'b0;
    break_req_d = (pend_d != '0);
    status_d = status_q;
    if (commit && !pwrite && slot == dbu_pkg::DBU_SLOT_STATUS) status_d = 16'h0000;
    if (match_hit) begin
      status_d[`DBU_ST_BREAK] = 1'b1;
      if (bus_is_fetch) status_d[`DBU_ST_FETCH] = 1'b1;
    end
    irq_d = |(status_d & imask_d);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 5; i++) begin
        cfg_q[i] <= `DBU_CFG_RESET;
      end
      imask_q <= 16'h0000;
      status_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      pend_q <= '0;
      fetch_q <= 1'b0;
      break_req_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      imask_q <= imask_d;
      status_q <= status_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      pend_q <= pend_d;
      fetch_q <= fetch_d;
      break_req_q <= break_req_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign break_req = break_req_q;
  assign break_on_fetch = fetch_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_req_count;
    match_hit && !break_ack && (pend_q != {CNT_W{1'b1}}) |=> pend_q == $past(pend_q) + CNT_W'(1);
  endproperty
  a_req_count: assert property (p_req_count) else $error("match did not add one request");

  property p_req_hold;
    break_req && !break_ack && !match_hit |=> break_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before accept");

  property p_break_flag;
    match_hit |=> break_req && status_q[`DBU_ST_BREAK];
  endproperty
  a_break_flag: assert property (p_break_flag) else $error("match raised no request");

  property p_fetch;
    match_hit && bus_is_fetch |=> break_on_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch break not flagged");

  property p_src_off;
    cfg_q[4][`DBU_SRC_POS +: 2] == 2'h0 |-> !match_hit;
  endproperty
  a_src_off: assert property (p_src_off) else $error("break with source field zero");

  property p_type_off;
    cfg_q[4][`DBU_TYPE_POS +: 2] == 2'h0 |-> !match_hit;
  endproperty
  a_type_off: assert property (p_type_off) else $error("break with access field zero");

  property p_dir_sel;
    match_hit |-> (bus_is_write ? cfg_q[4][`DBU_DIR_POS + 1] : cfg_q[4][`DBU_DIR_POS]);
  endproperty
  a_dir_sel: assert property (p_dir_sel) else $error("direction not selected");

  property p_size;
    match_hit && cfg_q[4][`DBU_SIZE_POS +: 2] != `DBU_SIZE_ANY
      |-> bus_size == cfg_q[4][`DBU_SIZE_POS +: 2];
  endproperty
  a_size: assert property (p_size) else $error("size condition ignored");

  property p_addr_mask;
    match_hit |-> ((bus_addr ^ {cfg_q[0], cfg_q[1]}) & ~{cfg_q[2], cfg_q[3]}) == 32'h0;
  endproperty
  a_addr_mask: assert property (p_addr_mask) else $error("address mismatch broke");

  sequence s_full_write_hi;
    psel && penable && pready && pwrite && pstrb[1:0] == 2'h3
      && slot == dbu_pkg::DBU_SLOT_ADDR_HI;
  endsequence
  property p_write_hi;
    s_full_write_hi |=> cfg_q[0] == $past(pwdata[15:0]);
  endproperty
  a_write_hi: assert property (p_write_hi) else $error("setting write lost");

  property p_reserved;
    cfg_q[4][15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved select bits set");

  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");

  property p_irq;
    irq == |(status_q & imask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_ack_drop;
    pend_q == CNT_W'(1) && break_ack && !match_hit |=> !break_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after last accept");

  property p_status_clear;
    commit && !pwrite && slot == dbu_pkg::DBU_SLOT_STATUS && !match_hit
      |=> status_q == 16'h0000;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_unmapped;
    psel && penable && !pready && slot == dbu_pkg::DBU_SLOT_NONE |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_read_lo;
    psel && penable && !pready && !pwrite && slot == dbu_pkg::DBU_SLOT_ADDR_LO
      |=> prdata == {16'h0000, $past(cfg_q[1])};
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("setting read wrong");

  property p_sel_stable;
    !(commit && pwrite) |=> $stable(cfg_q[4]);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select changed unwritten");

  property p_fetch_clear;
    !match_hit && pend_d == '0 |=> !break_on_fetch;
  endproperty
  a_fetch_clear: assert property (p_fetch_clear) else $error("fetch flag outlived requests");

endmodule : dbu_top

// File: verification/dbu_core_model.sv
`timescale 1ns/1ps
module dbu_core_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic break_req,
  input wire logic [3:0] ack_dly,
  output logic break_ack,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic bus_is_dma,
  output logic bus_is_fetch,
  output logic bus_is_write,
  output logic [1:0] bus_size
);
  logic [3:0] wait_q;
  int n_ack = 0;
  initial begin
    {bus_valid, bus_addr, bus_is_dma, bus_is_fetch, bus_is_write, bus_size} = '0;
  end
  // n watched cycles of one kind; lines show garbage once released
  task automatic cycle(input logic [31:0] a, input logic [4:0] k, input int n);
    @(posedge clk_sys);
    bus_valid <= 1'b1;
    bus_addr <= a;
    {bus_is_dma, bus_is_fetch, bus_is_write, bus_size} <= k;
    repeat (n) @(posedge clk_sys);
    bus_valid <= 1'b0;
    bus_addr <= ~a;
    {bus_is_dma, bus_is_fetch, bus_is_write, bus_size} <= ~k;
  endtask : cycle
  // takes one pending request after ack_dly waiting cycles
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      break_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (break_req && !break_ack && wait_q >= ack_dly) begin
      break_ack <= 1'b1;
      wait_q <= 4'h0;
      n_ack <= n_ack + 1;
    end else begin
      break_ack <= 1'b0;
      if (break_req && !break_ack) wait_q <= wait_q + 4'h1;
    end
  end
endmodule : dbu_core_model

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "dbu_regs.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, bus_addr, rd, baddr;
  logic pready, pslverr, bus_valid, bus_is_dma, bus_is_fetch, bus_is_write, err;
  logic [1:0] bus_size;
  logic break_req, break_on_fetch, break_ack, irq;
  logic [3:0] ack_dly = 4'h6;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  always #50 clk_sys = ~clk_sys;
  dbu_top #(.CNT_W(4)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_is_dma(bus_is_dma), .bus_is_fetch(bus_is_fetch),
    .bus_is_write(bus_is_write), .bus_size(bus_size), .break_req(break_req),
    .break_on_fetch(break_on_fetch), .break_ack(break_ack), .irq(irq));
  dbu_core_model i_core (.clk_sys(clk_sys), .reset_n(reset_n), .break_req(break_req),
    .ack_dly(ack_dly), .break_ack(break_ack), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_is_dma(bus_is_dma), .bus_is_fetch(bus_is_fetch), .bus_is_write(bus_is_write),
    .bus_size(bus_size));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [27:0] idx, input logic [15:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one watched cycle; kind is {dma, fetch, write, size}
  task automatic row(input logic [7:0] sel, input logic [4:0] k, input logic e);
    apb(1'b1, `DBU_IDX_CYC_SEL, {8'h0, sel}, 4'hf);
    i_core.cycle(baddr, k, 1);
    @(negedge clk_sys);
    chk(break_req, e);
    if (e) chk(break_on_fetch, k[3]);
    while (break_req !== 1'b0) @(negedge clk_sys);
  endtask : row
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, `DBU_IDX_ADDR_HI + 28'(2 * i), 16'h0, 4'hf);
      chk(rd, 32'h0);
      apb(1'b1, (`DBU_IDX_ADDR_HI + 28'(2 * i)) ^ 28'h0001000, 16'ha5c3, 4'hf);
      apb(1'b0, `DBU_IDX_ADDR_HI + 28'(2 * i), 16'h0, 4'hf);
      chk(rd, (i == 4) ? 32'h00c3 : 32'ha5c3);
    end
    apb(1'b1, `DBU_IDX_ADDR_LO, 16'h0f0f, 4'h1);
    apb(1'b0, `DBU_IDX_ADDR_LO, 16'h0, 4'hf);
    chk(rd, 32'ha50f);
    apb(1'b0, 28'h4ffff90, 16'h0, 4'hf);
    chk(err, 1'b1);
    $display("regs test done");
  endtask : t_regs
  task automatic t_match();
    apb(1'b1, `DBU_IDX_ADDR_HI, 16'h1234, 4'hf);
    apb(1'b1, `DBU_IDX_ADDR_LO, 16'h5678, 4'hf);
    apb(1'b1, `DBU_IDX_MASK_LO, 16'h0, 4'hf);
    baddr = 32'h12345678;
    row(8'h15, 5'h09, 1'b0);
    row(8'h55, 5'h09, 1'b1);
    row(8'h55, 5'h19, 1'b0);
    row(8'h95, 5'h09, 1'b0);
    row(8'h95, 5'h19, 1'b1);
    row(8'hd5, 5'h19, 1'b1);
    row(8'h45, 5'h01, 1'b0);
    row(8'h65, 5'h09, 1'b0);
    row(8'h65, 5'h01, 1'b1);
    row(8'h75, 5'h01, 1'b1);
    row(8'h51, 5'h09, 1'b0);
    row(8'h59, 5'h09, 1'b0);
    row(8'h59, 5'h0d, 1'b1);
    row(8'h5d, 5'h0d, 1'b1);
    row(8'h56, 5'h09, 1'b0);
    row(8'h56, 5'h0a, 1'b1);
    row(8'h57, 5'h0a, 1'b0);
    row(8'h57, 5'h0b, 1'b1);
    row(8'h54, 5'h09, 1'b1);
    baddr = 32'h12345679;
    row(8'h54, 5'h09, 1'b0);
    apb(1'b1, `DBU_IDX_MASK_LO, 16'h0001, 4'hf);
    row(8'h54, 5'h09, 1'b1);
    baddr = 32'h12345779;
    row(8'h54, 5'h09, 1'b0);
    $display("match test done");
  endtask : t_match
  task automatic t_pend();
    int a0;
    a0 = i_core.n_ack;
    ack_dly <= 4'h0;
    baddr = 32'h12345678;
    i_core.cycle(baddr, 5'h09, 2);
    @(negedge clk_sys);
    chk(break_req, 1'b1);
    repeat (12) @(negedge clk_sys);
    chk(break_req, 1'b0);
    chk(32'(i_core.n_ack - a0), 32'h2);
    $display("pending test done");
  endtask : t_pend
  task automatic t_irq();
    apb(1'b1, `DBU_IDX_IRQ_MASK, 16'h0001, 4'hf);
    apb(1'b0, `DBU_IDX_STATUS, 16'h0, 4'hf);
    row(8'h65, 5'h01, 1'b1);
    chk(irq, 1'b1);
    apb(1'b0, `DBU_IDX_STATUS, 16'h0, 4'hf);
    chk(rd, 32'h1);
    repeat (2) @(negedge clk_sys);
    chk(irq, 1'b0);
    apb(1'b1, `DBU_IDX_IRQ_MASK, 16'h0, 4'hf);
    row(8'h55, 5'h09, 1'b1);
    chk(irq, 1'b0);
    apb(1'b0, `DBU_IDX_STATUS, 16'h0, 4'hf);
    chk(rd, 32'h3);
    $display("irq test done");
  endtask : t_irq
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_match();
    t_pend();
    t_irq();
    test_done();
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end
endmodule : testbench
